// >>> logic/vdcr_map.svh
// Register offsets, reset values, write masks, field positions and timing counts.
// Assumes inclusion by its bare name from the package and the design modules.
`ifndef VDCR_MAP_SVH
`define VDCR_MAP_SVH

// =============================================================
// Register offsets
`define VDCR_OFS_DIV_HIGH     4'h0
`define VDCR_OFS_DIV_LOW      4'h1
`define VDCR_OFS_GAIN_RED     4'h2
`define VDCR_OFS_GAIN_GREEN   4'h3
`define VDCR_OFS_GAIN_BLUE    4'h4
`define VDCR_OFS_BLACK_RED    4'h5
`define VDCR_OFS_BLACK_GREEN  4'h6
`define VDCR_OFS_BLACK_BLUE   4'h7
`define VDCR_OFS_CLAMP_START  4'h8
`define VDCR_OFS_CLAMP_LEN    4'h9
`define VDCR_OFS_GEN_CTRL_ONE 4'ha
`define VDCR_OFS_SAMPLE_PHASE 4'hb
`define VDCR_OFS_OSC_RANGE    4'hc
`define VDCR_OFS_GEN_CTRL_TWO 4'hd
`define VDCR_REG_COUNT        16

// =============================================================
// Power-up values
`define VDCR_RST_DIV_HIGH     8'h69
`define VDCR_RST_DIV_LOW      8'hd0
`define VDCR_RST_GAIN         8'h80
`define VDCR_RST_BLACK        8'h80
`define VDCR_RST_CLAMP        8'h80
`define VDCR_RST_GEN_CTRL_ONE 8'hf4
`define VDCR_RST_SAMPLE_PHASE 8'h80
`define VDCR_RST_OSC_RANGE    8'h24
`define VDCR_RST_ZERO         8'h00

// =============================================================
// Writable bits per register; reserved bits are not stored and read as zero
`define VDCR_WM_FULL          8'hff
`define VDCR_WM_DIV_LOW       8'hf0
`define VDCR_WM_BLACK         8'hfc
`define VDCR_WM_GEN_CTRL_ONE  8'hfe
`define VDCR_WM_SAMPLE_PHASE  8'hf8
`define VDCR_WM_OSC_RANGE     8'h7c
`define VDCR_WM_GEN_CTRL_TWO  8'h10

// =============================================================
// Field positions
`define VDCR_CTL_DEMUX        7
`define VDCR_CTL_PARALLEL     6
`define VDCR_CTL_HSYNC_POL    5
`define VDCR_CTL_COAST_POL    4
`define VDCR_CTL_EXT_CLAMP    3
`define VDCR_CTL_CLAMP_POL    2
`define VDCR_CTL_EXT_CLOCK    1
`define VDCR_CTL_OUT_PHASE    4
`define VDCR_CMD_READ_BIT     7

// =============================================================
// Serial link timing: half period of the serial clock in system clocks
`define VDCR_HALF_CYC         4'h8
`define VDCR_FRAME_LAST       4'hf
`define VDCR_BYTE_LAST        4'h7
`define VDCR_TX_BITS          4'h8

`endif

// >>> logic/vdcr_pkg.sv
// Types shared by the two ends of the control register link.
// Assumes the constants header sits beside it on the include path.
package vdcr_pkg;
  `include "vdcr_map.svh"

  typedef logic [7:0] vdcr_byte_t;
  typedef logic [3:0] vdcr_addr_t;

  // =============================================================
  // State machines
  typedef enum logic [2:0] {D_IDLE, D_CMD, D_WR, D_TX, D_DONE} vdcr_dev_state_t;
  typedef enum logic [2:0] {H_IDLE, H_START, H_SETUP, H_RISE, H_FALL, H_STOP1, H_STOP2}
    vdcr_host_state_t;
endpackage : vdcr_pkg

// >>> logic/vdcr_if.sv
// Two-wire serial link between the controller and the register bank.
// Assumes the data line is open drain with a pull-up; the clock is driven by the controller.
`timescale 1ns/1ps
`default_nettype none

interface vdcr_if;
  logic scl;
  logic host_sda_o;
  logic host_sda_oe;
  logic dev_sda_o;
  logic dev_sda_oe;
  logic sda;

  // Wired-AND of both drivers over the pull-up level.
  assign sda = (host_sda_oe ? host_sda_o : 1'b1) & (dev_sda_oe ? dev_sda_o : 1'b1);

  modport host   (output scl, output host_sda_o, output host_sda_oe, input sda);
  modport device (input scl, input sda, output dev_sda_o, output dev_sda_oe);
endinterface : vdcr_if

`default_nettype wire

// >>> logic/vdcr_host.sv
// Controller end: turns one register command into a serial frame on the link.
// Assumes the device end samples the link through synchronisers on the same clock rate.
`timescale 1ns/1ps
`default_nettype none

`include "vdcr_map.svh"

module vdcr_host (
  input  wire logic              clk_sys,
  input  wire logic              rstn,
  vdcr_if.host                   link,
  input  wire logic              cmd_valid,
  output logic                   cmd_ready,
  input  wire logic              cmd_write,
  input  wire vdcr_pkg::vdcr_addr_t cmd_addr,
  input  wire vdcr_pkg::vdcr_byte_t cmd_wdata,
  output logic                   rsp_valid,
  output vdcr_pkg::vdcr_byte_t   rsp_rdata
);
  import vdcr_pkg::*;

  vdcr_host_state_t st_r, st_nxt;
  logic [3:0]  tdiv_r, tdiv_nxt;
  logic        tick_r, tick_nxt;
  logic [15:0] frame_r, frame_nxt;
  logic        rd_r, rd_nxt;
  logic [3:0]  cnt_r, cnt_nxt;
  vdcr_byte_t  rsh_r, rsh_nxt;
  logic        scl_r, scl_nxt;
  logic        oe_r, oe_nxt;
  logic        ready_r, ready_nxt;
  logic        rv_r, rv_nxt;
  vdcr_byte_t  rdata_r, rdata_nxt;
  logic        sda_m_r, sda_q_r;

  // Release the line for the device's data bits of a read, else pull low for a zero.
  function automatic logic drive_low(input logic [15:0] fr, input logic [3:0] idx,
                                     input logic rd);
    drive_low = (idx <= `VDCR_BYTE_LAST || !rd) ? ~fr[`VDCR_FRAME_LAST - idx] : 1'b0;
  endfunction : drive_low

  // =============================================================
  // Next-state logic; the tick paces every link edge at one half period.
  always_comb begin
    tdiv_nxt  = (tdiv_r == `VDCR_HALF_CYC - 4'h1) ? 4'h0 : tdiv_r + 4'h1;
    tick_nxt  = (tdiv_r == `VDCR_HALF_CYC - 4'h1);
    st_nxt    = st_r;
    frame_nxt = frame_r;
    rd_nxt    = rd_r;
    cnt_nxt   = cnt_r;
    rsh_nxt   = rsh_r;
    scl_nxt   = scl_r;
    oe_nxt    = oe_r;
    rv_nxt    = 1'b0;
    rdata_nxt = rdata_r;
    case (st_r)
      H_IDLE: begin
        if (cmd_valid && ready_r) begin
          rd_nxt    = !cmd_write;
          frame_nxt = {!cmd_write, 3'h0, cmd_addr, cmd_write ? cmd_wdata : 8'h00};
          cnt_nxt   = 4'h0;
          st_nxt    = H_START;
        end
      end
      H_START: if (tick_r) begin
        oe_nxt = 1'b1; // Data falls while the clock is high: frame start.
        st_nxt = H_SETUP;
      end
      H_SETUP: if (tick_r) begin
        scl_nxt = 1'b0;
        oe_nxt  = drive_low(frame_r, cnt_r, rd_r);
        st_nxt  = H_RISE;
      end
      H_RISE: if (tick_r) begin
        scl_nxt = 1'b1;
        st_nxt  = H_FALL;
      end
      H_FALL: if (tick_r) begin
        scl_nxt = 1'b0;
        if (cnt_r > `VDCR_BYTE_LAST) begin
          rsh_nxt = {rsh_r[6:0], sda_q_r};
        end
        if (cnt_r == `VDCR_FRAME_LAST) begin
          oe_nxt = 1'b1; // Hold data low so the stop can be a rising edge.
          st_nxt = H_STOP1;
        end else begin
          cnt_nxt = cnt_r + 4'h1;
          oe_nxt  = drive_low(frame_r, cnt_r + 4'h1, rd_r);
          st_nxt  = H_RISE;
        end
      end
      H_STOP1: if (tick_r) begin
        scl_nxt = 1'b1;
        st_nxt  = H_STOP2;
      end
      H_STOP2: if (tick_r) begin
        oe_nxt    = 1'b0; // Data rises while the clock is high: frame stop.
        rv_nxt    = 1'b1;
        rdata_nxt = rd_r ? rsh_r : 8'h00;
        st_nxt    = H_IDLE;
      end
      default: st_nxt = H_IDLE;
    endcase
    ready_nxt = (st_nxt == H_IDLE);
  end

  // =============================================================
  // State registers, plus a two-stage synchroniser for the shared data line.
  always_ff @(posedge clk_sys) begin
    sda_m_r <= link.sda;
    sda_q_r <= sda_m_r;
    if (!rstn) begin
      st_r    <= H_IDLE;
      tdiv_r  <= 4'h0;
      tick_r  <= 1'b0;
      frame_r <= 16'h0000;
      rd_r    <= 1'b0;
      cnt_r   <= 4'h0;
      rsh_r   <= 8'h00;
      scl_r   <= 1'b1;
      oe_r    <= 1'b0;
      ready_r <= 1'b0;
      rv_r    <= 1'b0;
      rdata_r <= 8'h00;
    end else begin
      st_r    <= st_nxt;
      tdiv_r  <= tdiv_nxt;
      tick_r  <= tick_nxt;
      frame_r <= frame_nxt;
      rd_r    <= rd_nxt;
      cnt_r   <= cnt_nxt;
      rsh_r   <= rsh_nxt;
      scl_r   <= scl_nxt;
      oe_r    <= oe_nxt;
      ready_r <= ready_nxt;
      rv_r    <= rv_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  // The line is open drain, so the driven level is always low.
  assign link.scl         = scl_r;
  assign link.host_sda_o  = 1'b0;
  assign link.host_sda_oe = oe_r;
  assign cmd_ready        = ready_r;
  assign rsp_valid        = rv_r;
  assign rsp_rdata        = rdata_r;
endmodule : vdcr_host

`default_nettype wire

// >>> logic/vdcr_device.sv
// Device end: the video digitizer control register bank behind the serial link.
// Assumes the link pins come from another domain and pix_tick from logic on clk_sys.
`timescale 1ns/1ps
`default_nettype none

`include "vdcr_map.svh"

module vdcr_device #(
  parameter logic [2:0] DIE_REVISION = 3'h5 // Arbitrary value.
) (
  input  wire logic              clk_sys,
  input  wire logic              rstn,
  vdcr_if.device                 link,
  input  wire logic              pix_tick,
  output logic [11:0]            line_divide_value,
  output logic [12:0]            line_divide_ratio,
  output logic                   line_mark,
  output vdcr_pkg::vdcr_byte_t   gain_channel_red,
  output vdcr_pkg::vdcr_byte_t   gain_channel_green,
  output vdcr_pkg::vdcr_byte_t   gain_channel_blue,
  output logic [5:0]             black_level_red,
  output logic [5:0]             black_level_green,
  output logic [5:0]             black_level_blue,
  output vdcr_pkg::vdcr_byte_t   clamp_start_position,
  output vdcr_pkg::vdcr_byte_t   clamp_length,
  output logic                   demux_enable,
  output logic                   parallel_timing,
  output logic                   hsync_active_high,
  output logic                   coast_active_high,
  output logic                   ext_clamp_select,
  output logic                   clamp_active_high,
  output logic                   ext_clock_select,
  output logic [4:0]             sample_phase,
  output logic [1:0]             oscillator_range,
  output logic [2:0]             pump_current,
  output logic                   output_port_phase
);
  import vdcr_pkg::*;

  // Power-up contents of each register slot.
  function automatic vdcr_byte_t reset_value(input vdcr_addr_t a);
    case (a)
      `VDCR_OFS_DIV_HIGH:     reset_value = `VDCR_RST_DIV_HIGH;
      `VDCR_OFS_DIV_LOW:      reset_value = `VDCR_RST_DIV_LOW;
      `VDCR_OFS_GAIN_RED,
      `VDCR_OFS_GAIN_GREEN,
      `VDCR_OFS_GAIN_BLUE:    reset_value = `VDCR_RST_GAIN;
      `VDCR_OFS_BLACK_RED,
      `VDCR_OFS_BLACK_GREEN,
      `VDCR_OFS_BLACK_BLUE:   reset_value = `VDCR_RST_BLACK;
      `VDCR_OFS_CLAMP_START,
      `VDCR_OFS_CLAMP_LEN:    reset_value = `VDCR_RST_CLAMP;
      `VDCR_OFS_GEN_CTRL_ONE: reset_value = `VDCR_RST_GEN_CTRL_ONE;
      `VDCR_OFS_SAMPLE_PHASE: reset_value = `VDCR_RST_SAMPLE_PHASE;
      `VDCR_OFS_OSC_RANGE:    reset_value = `VDCR_RST_OSC_RANGE;
      default:                reset_value = `VDCR_RST_ZERO;
    endcase
  endfunction : reset_value

  // Bits that a write may change; reserved bits and the revision are never stored.
  function automatic vdcr_byte_t write_mask(input vdcr_addr_t a);
    case (a)
      `VDCR_OFS_DIV_LOW:      write_mask = `VDCR_WM_DIV_LOW;
      `VDCR_OFS_BLACK_RED,
      `VDCR_OFS_BLACK_GREEN,
      `VDCR_OFS_BLACK_BLUE:   write_mask = `VDCR_WM_BLACK;
      `VDCR_OFS_GEN_CTRL_ONE: write_mask = `VDCR_WM_GEN_CTRL_ONE;
      `VDCR_OFS_SAMPLE_PHASE: write_mask = `VDCR_WM_SAMPLE_PHASE;
      `VDCR_OFS_OSC_RANGE:    write_mask = `VDCR_WM_OSC_RANGE;
      `VDCR_OFS_GEN_CTRL_TWO: write_mask = `VDCR_WM_GEN_CTRL_TWO;
      `VDCR_OFS_GEN_CTRL_TWO + 4'h1,
      `VDCR_OFS_GEN_CTRL_TWO + 4'h2: write_mask = `VDCR_RST_ZERO;
      default:                write_mask = `VDCR_WM_FULL;
    endcase
  endfunction : write_mask

  vdcr_dev_state_t st_r, st_nxt;
  logic [3:0]  cnt_r, cnt_nxt;
  vdcr_byte_t  sh_r, sh_nxt;
  vdcr_addr_t  addr_r, addr_nxt;
  logic        oe_r, oe_nxt;
  vdcr_byte_t  regs_r [`VDCR_REG_COUNT];
  vdcr_byte_t  regs_nxt [`VDCR_REG_COUNT];
  logic        scl_m_r, scl_q_r, scl_p_r;
  logic        sda_m_r, sda_q_r, sda_p_r;
  logic        rise, fall, start, stop;
  vdcr_byte_t  in_byte;
  vdcr_byte_t  rd_byte;
  logic [11:0] div_value;
  logic [11:0] div_cnt_r, div_cnt_nxt;
  logic [12:0] ratio_r, ratio_nxt;
  logic        mark_r, mark_nxt;

  // =============================================================
  // Link conditions, seen only after the second synchroniser stage.
  assign rise    = scl_q_r & ~scl_p_r;
  assign fall    = ~scl_q_r & scl_p_r;
  assign start   = scl_q_r & scl_p_r & sda_p_r & ~sda_q_r;
  assign stop    = scl_q_r & scl_p_r & ~sda_p_r & sda_q_r;
  assign in_byte = {sh_r[6:0], sda_q_r};

  // The revision field is merged in on read only, so writes cannot reach it.
  always_comb begin
    rd_byte = regs_r[in_byte[3:0]];
    if (in_byte[3:0] == `VDCR_OFS_GEN_CTRL_TWO) begin
      rd_byte = rd_byte | {4'h0, DIE_REVISION, 1'b0};
    end
  end

  // =============================================================
  // Serial frame decoder: command byte, then one data byte in or out.
  // A start anywhere restarts the frame, so a frame broken before its sixteenth clock rise never writes.
  always_comb begin
    st_nxt   = st_r;
    cnt_nxt  = cnt_r;
    sh_nxt   = sh_r;
    addr_nxt = addr_r;
    oe_nxt   = oe_r;
    regs_nxt = regs_r;
    if (start) begin
      st_nxt  = D_CMD;
      cnt_nxt = 4'h0;
      oe_nxt  = 1'b0;
    end else if (stop) begin
      st_nxt = D_IDLE;
      oe_nxt = 1'b0;
    end else begin
      case (st_r)
        D_CMD: if (rise) begin
          sh_nxt  = in_byte;
          cnt_nxt = cnt_r + 4'h1;
          if (cnt_r == `VDCR_BYTE_LAST) begin
            cnt_nxt  = 4'h0;
            addr_nxt = in_byte[3:0];
            if (in_byte[`VDCR_CMD_READ_BIT]) begin
              sh_nxt = rd_byte;
              st_nxt = D_TX;
            end else begin
              st_nxt = D_WR;
            end
          end
        end
        D_WR: if (rise) begin
          sh_nxt  = in_byte;
          cnt_nxt = cnt_r + 4'h1;
          if (cnt_r == `VDCR_BYTE_LAST) begin
            regs_nxt[addr_r] = in_byte & write_mask(addr_r);
            st_nxt           = D_DONE;
          end
        end
        D_TX: if (fall) begin
          if (cnt_r == `VDCR_TX_BITS) begin
            oe_nxt = 1'b0; // Release the line before the controller's stop.
            st_nxt = D_DONE;
          end else begin
            oe_nxt  = ~sh_r[7];
            sh_nxt  = {sh_r[6:0], 1'b0};
            cnt_nxt = cnt_r + 4'h1;
          end
        end
        D_IDLE, D_DONE: st_nxt = st_r;
        default:        st_nxt = D_IDLE;
      endcase
    end
  end

  // =============================================================
  // Line divider: counts master ticks, one mark every value-plus-one ticks.
  // The analog lock to incoming sync lies outside this logic.
  assign div_value = {regs_r[`VDCR_OFS_DIV_HIGH], regs_r[`VDCR_OFS_DIV_LOW][7:4]};
  always_comb begin
    ratio_nxt   = {1'b0, div_value} + 13'h0001;
    div_cnt_nxt = div_cnt_r;
    mark_nxt    = 1'b0;
    if (pix_tick) begin
      if (div_cnt_r >= div_value) begin
        div_cnt_nxt = 12'h000;
        mark_nxt    = 1'b1;
      end else begin
        div_cnt_nxt = div_cnt_r + 12'h001;
      end
    end
  end

  // =============================================================
  // State registers; the link pins pass two stages before any use.
  always_ff @(posedge clk_sys) begin
    scl_m_r <= link.scl;
    scl_q_r <= scl_m_r;
    sda_m_r <= link.sda;
    sda_q_r <= sda_m_r;
    if (!rstn) begin
      scl_p_r   <= 1'b1;
      sda_p_r   <= 1'b1;
      st_r      <= D_IDLE;
      cnt_r     <= 4'h0;
      sh_r      <= 8'h00;
      addr_r    <= 4'h0;
      oe_r      <= 1'b0;
      div_cnt_r <= 12'h000;
      ratio_r   <= 13'h0000;
      mark_r    <= 1'b0;
      for (int i = 0; i < `VDCR_REG_COUNT; i++) begin
        regs_r[i] <= reset_value(4'(i));
      end
    end else begin
      scl_p_r   <= scl_q_r;
      sda_p_r   <= sda_q_r;
      st_r      <= st_nxt;
      cnt_r     <= cnt_nxt;
      sh_r      <= sh_nxt;
      addr_r    <= addr_nxt;
      oe_r      <= oe_nxt;
      div_cnt_r <= div_cnt_nxt;
      ratio_r   <= ratio_nxt;
      mark_r    <= mark_nxt;
      regs_r    <= regs_nxt;
    end
  end

  // =============================================================
  // Field outputs, sliced straight from the register flops.
  assign link.dev_sda_o      = 1'b0;
  assign link.dev_sda_oe     = oe_r;
  assign line_divide_value   = div_value;
  assign line_divide_ratio   = ratio_r;
  assign line_mark           = mark_r;
  assign gain_channel_red    = regs_r[`VDCR_OFS_GAIN_RED];
  assign gain_channel_green  = regs_r[`VDCR_OFS_GAIN_GREEN];
  assign gain_channel_blue   = regs_r[`VDCR_OFS_GAIN_BLUE];
  assign black_level_red     = regs_r[`VDCR_OFS_BLACK_RED][7:2];
  assign black_level_green   = regs_r[`VDCR_OFS_BLACK_GREEN][7:2];
  assign black_level_blue    = regs_r[`VDCR_OFS_BLACK_BLUE][7:2];
  assign clamp_start_position = regs_r[`VDCR_OFS_CLAMP_START];
  assign clamp_length        = regs_r[`VDCR_OFS_CLAMP_LEN];
  assign demux_enable        = regs_r[`VDCR_OFS_GEN_CTRL_ONE][`VDCR_CTL_DEMUX];
  assign parallel_timing     = regs_r[`VDCR_OFS_GEN_CTRL_ONE][`VDCR_CTL_PARALLEL];
  assign hsync_active_high   = regs_r[`VDCR_OFS_GEN_CTRL_ONE][`VDCR_CTL_HSYNC_POL];
  assign coast_active_high   = regs_r[`VDCR_OFS_GEN_CTRL_ONE][`VDCR_CTL_COAST_POL];
  assign ext_clamp_select    = regs_r[`VDCR_OFS_GEN_CTRL_ONE][`VDCR_CTL_EXT_CLAMP];
  assign clamp_active_high   = regs_r[`VDCR_OFS_GEN_CTRL_ONE][`VDCR_CTL_CLAMP_POL];
  assign ext_clock_select    = regs_r[`VDCR_OFS_GEN_CTRL_ONE][`VDCR_CTL_EXT_CLOCK];
  assign sample_phase        = regs_r[`VDCR_OFS_SAMPLE_PHASE][7:3];
  assign oscillator_range    = regs_r[`VDCR_OFS_OSC_RANGE][6:5];
  assign pump_current        = regs_r[`VDCR_OFS_OSC_RANGE][4:2];
  assign output_port_phase   = regs_r[`VDCR_OFS_GEN_CTRL_TWO][`VDCR_CTL_OUT_PHASE];
endmodule : vdcr_device

`default_nettype wire

// >>> verif/vdcr_link_props.sv
// Checker for the serial link between the controller and the register bank.
// Assumes instantiation beside the link interface, fed with its signals by name.
`timescale 1ns/1ps
`default_nettype none

module vdcr_link_props (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic scl,
  input wire logic host_sda_o,
  input wire logic host_sda_oe,
  input wire logic dev_sda_o,
  input wire logic dev_sda_oe,
  input wire logic sda
);
  logic       scl_r;
  logic       sda_r;
  logic [4:0] bits_r;
  logic       start_w;
  logic       stop_w;

  // =============================================================
  // Frame tracking
  // Data edges while the clock stays high mark the frame bounds.
  assign start_w = scl && scl_r && sda_r && !sda;
  assign stop_w  = scl && scl_r && !sda_r && sda;

  // Clock rises since the last start; saturates so a stuck link never wraps.
  always_ff @(posedge clk_sys) begin
    scl_r <= rstn ? scl : 1'h1;
    sda_r <= rstn ? sda : 1'h1;
    if (!rstn || start_w) begin
      bits_r <= 5'h00;
    end else if (scl && !scl_r && bits_r != 5'h1f) begin
      bits_r <= bits_r + 5'h01;
    end
  end

  // =============================================================
  // Properties
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);

  a_drive_only_low: assert property (
    !(host_sda_oe && host_sda_o) && !(dev_sda_oe && dev_sda_o))
    else $error("data line driven high");
  a_clock_high_hold: assert property ($rose(scl) |-> scl[*8])
    else $error("clock high phase short");
  a_clock_low_hold: assert property ($fell(scl) |-> !scl[*8])
    else $error("clock low phase short");
  a_dev_change_low: assert property ($changed(dev_sda_oe) |-> !scl)
    else $error("device data changed with clock high");
  // Sixteen data rises, plus the clock rise that sets up the stop condition.
  a_frame_sixteen: assert property (stop_w |-> bits_r == 5'h11)
    else $error("frame not sixteen bits");
  a_dev_data_phase: assert property (dev_sda_oe |-> bits_r >= 5'h08)
    else $error("device drove during command byte");
  a_start_then_fall: assert property (start_w |-> scl[*7] ##[1:2] !scl)
    else $error("clock did not fall after start");
  a_data_steady: assert property (scl && scl_r && !start_w && !stop_w |-> sda == sda_r)
    else $error("data moved while clock high");

  c_start: cover property (start_w);
  c_stop: cover property (stop_w);
  c_dev_read: cover property (dev_sda_oe && scl);
endmodule : vdcr_link_props

`default_nettype wire

// >>> verif/video_digitizer_control_regs_test.sv
// Self-checking bench: controller end and register bank joined over the link.
// Assumes the design package, interface and both ends are compiled first.
`timescale 1ns/1ps
`default_nettype none

module video_digitizer_control_regs_test;
  import vdcr_pkg::*;
  typedef struct packed {vdcr_byte_t wd; vdcr_byte_t rd;} vdcr_row_t;
  localparam logic [2:0] REV = 3'h5; // Arbitrary revision value.
  logic        clk_sys;
  logic        rstn;
  logic        cmd_valid;
  logic        cmd_ready;
  logic        cmd_write;
  vdcr_addr_t  cmd_addr;
  vdcr_byte_t  cmd_wdata;
  logic        rsp_valid;
  vdcr_byte_t  rsp_rdata;
  logic        pix_tick;
  logic [11:0] line_divide_value;
  logic [12:0] line_divide_ratio;
  logic        line_mark;
  vdcr_byte_t  gain_red;
  vdcr_byte_t  gain_green;
  vdcr_byte_t  gain_blue;
  logic [5:0]  black_red;
  logic [5:0]  black_green;
  logic [5:0]  black_blue;
  vdcr_byte_t  clamp_start;
  vdcr_byte_t  clamp_len;
  wire   [6:0] gen_ctl;
  logic  [4:0] phase;
  logic  [1:0] osc_range;
  logic  [2:0] pump;
  logic        out_phase;
  int          fail_count = 0;
  int          checks = 0;
  int          cycles = 0;
  vdcr_byte_t  q;
  int          n;
  vdcr_byte_t  rst_tab [16] = '{8'h69, 8'hd0, 8'h80, 8'h80, 8'h80, 8'h80, 8'h80, 8'h80,
                                 8'h80, 8'h80, 8'hf4, 8'h80, 8'h24, {4'h0, REV, 1'h0}, 8'h00, 8'h00};
  // Written value beside the read-back value; reserved fields are written as zero, the revision bits at offset 0xd as ones.
  vdcr_row_t   rows [16] = '{16'h9696, 16'hf0f0, 16'h5a5a, 16'ha5a5, 16'h0101, 16'hfcfc,
                              16'h7c7c, 16'h0404, 16'h0808, 16'h1010, 16'h0a0a, 16'hf8f8,
                              16'h7c7c, {8'h1e, 3'h0, 1'h1, REV, 1'h0}, 16'h0000, 16'h0000};
  vdcr_byte_t  div_lo [3] = '{8'h10, 8'h40, 8'ha0};

  vdcr_if vdcr_if_i ();
  vdcr_host vdcr_host_i (.clk_sys(clk_sys), .rstn(rstn), .link(vdcr_if_i), .cmd_valid(cmd_valid),
    .cmd_ready(cmd_ready), .cmd_write(cmd_write), .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata),
    .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata));
  vdcr_device #(.DIE_REVISION(REV)) vdcr_device_i (.clk_sys(clk_sys), .rstn(rstn),
    .link(vdcr_if_i), .pix_tick(pix_tick), .line_divide_value(line_divide_value),
    .line_divide_ratio(line_divide_ratio), .line_mark(line_mark), .gain_channel_red(gain_red),
    .gain_channel_green(gain_green), .gain_channel_blue(gain_blue), .black_level_red(black_red),
    .black_level_green(black_green), .black_level_blue(black_blue),
    .clamp_start_position(clamp_start), .clamp_length(clamp_len), .demux_enable(gen_ctl[6]),
    .parallel_timing(gen_ctl[5]), .hsync_active_high(gen_ctl[4]),
    .coast_active_high(gen_ctl[3]), .ext_clamp_select(gen_ctl[2]),
    .clamp_active_high(gen_ctl[1]), .ext_clock_select(gen_ctl[0]), .sample_phase(phase),
    .oscillator_range(osc_range), .pump_current(pump), .output_port_phase(out_phase));
  vdcr_link_props vdcr_link_props_i (.clk_sys(clk_sys), .rstn(rstn), .scl(vdcr_if_i.scl),
    .host_sda_o(vdcr_if_i.host_sda_o), .host_sda_oe(vdcr_if_i.host_sda_oe),
    .dev_sda_o(vdcr_if_i.dev_sda_o), .dev_sda_oe(vdcr_if_i.dev_sda_oe), .sda(vdcr_if_i.sda));

  // =============================================================
  // Clock and hang guard
  initial begin
    clk_sys = 1'h0;
    forever #20 clk_sys = ~clk_sys;
  end

  // Fifty-four frames of some three hundred clocks each; the ceiling leaves double margin.
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      fail_count++;
      test_done();
    end
  end

  // =============================================================
  // Shared tasks
  task automatic test_done;
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : test_done

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // One command; the request is held until ready is seen, the answer taken with its pulse.
  task automatic xfer(input logic wr, input vdcr_addr_t a, input vdcr_byte_t d,
                      output vdcr_byte_t r);
    @(posedge clk_sys);
    cmd_valid <= 1'h1;
    cmd_write <= wr;
    cmd_addr  <= a;
    cmd_wdata <= d;
    // Outputs are looked at only on the falling edge, where they have settled.
    @(negedge clk_sys);
    for (int t = 0; t < 50 && cmd_ready !== 1'h1; t++) @(negedge clk_sys);
    @(posedge clk_sys);
    cmd_valid <= 1'h0;
    @(negedge clk_sys);
    for (int t = 0; t < 400 && rsp_valid !== 1'h1; t++) @(negedge clk_sys);
    r = rsp_rdata;
  endtask : xfer

  task automatic rdchk(input string what, input vdcr_addr_t a, input vdcr_byte_t e);
    vdcr_byte_t r;
    xfer(1'h0, a, 8'h00, r);
    check(what, {8'h00, r}, {8'h00, e});
  endtask : rdchk

  // Cycles from one line mark to the next, with a pixel tick every clock.
  task automatic gap(output int g);
    for (int t = 0; t < 9000 && line_mark !== 1'h1; t++) @(negedge clk_sys);
    g = 0;
    do begin
      @(negedge clk_sys);
      g++;
    end while (line_mark !== 1'h1 && g < 9000);
  endtask : gap

  // =============================================================
  // Main sequence
  initial begin
    rstn = 1'h0;
    cmd_valid = 1'h0;
    cmd_write = 1'h0;
    cmd_addr = 4'h0;
    cmd_wdata = 8'h00;
    pix_tick = 1'h1;
    repeat (2) @(posedge clk_sys);
    rstn <= 1'h1;
    @(negedge clk_sys);
    check("divide value", 16'(line_divide_value), 16'd1693);
    check("general control", 16'(gen_ctl), 16'h007a);
    check("sample phase", 16'(phase), 16'h0010);
    // The applied ratio is registered, so it settles one edge after release.
    @(negedge clk_sys);
    check("divide ratio", 16'(line_divide_ratio), 16'd1694);
    for (int i = 0; i < 16; i++) rdchk("reset value", 4'(i), rst_tab[i]);
    for (int i = 0; i < 16; i++) xfer(1'h1, 4'(i), rows[i].wd, q);
    for (int i = 0; i < 16; i++) rdchk("readback", 4'(i), rows[i].rd);
    check("divide value", 16'(line_divide_value), 16'h096f);
    check("divide ratio", 16'(line_divide_ratio), 16'h0970);
    check("gain red", 16'(gain_red), 16'h005a);
    check("gain green", 16'(gain_green), 16'h00a5);
    check("gain blue", 16'(gain_blue), 16'h0001);
    check("black red", 16'(black_red), 16'h003f);
    check("black green", 16'(black_green), 16'h001f);
    check("black blue", 16'(black_blue), 16'h0001);
    check("clamp start", 16'(clamp_start), 16'h0008);
    check("clamp length", 16'(clamp_len), 16'h0010);
    check("general control", 16'(gen_ctl), 16'h0005);
    check("sample phase", 16'(phase), 16'h001f);
    check("oscillator range", 16'(osc_range), 16'h0003);
    check("pump current", 16'(pump), 16'h0007);
    check("output phase", 16'(out_phase), 16'h0001);
    // A ratio of two first, then larger values must give longer lines.
    xfer(1'h1, 4'h0, 8'h00, q);
    for (int i = 0; i < 3; i++) begin
      xfer(1'h1, 4'h1, div_lo[i], q);
      gap(n);
      check("line length", 16'(n), 16'(div_lo[i][7:4]) + 16'h0001);
    end
    check("line length", 16'(n), 16'h000b);
    // Without master ticks the divider must stand still and mark nothing.
    @(posedge clk_sys);
    pix_tick <= 1'h0;
    repeat (3) @(posedge clk_sys);
    q = 8'h00;
    repeat (30) begin
      @(negedge clk_sys);
      q = q | {7'h00, line_mark};
    end
    check("mark without ticks", 16'(q), 16'h0000);
    @(posedge clk_sys);
    pix_tick <= 1'h1;
    // A second reset must bring back the power-up values.
    @(posedge clk_sys);
    rstn <= 1'h0;
    repeat (2) @(posedge clk_sys);
    rstn <= 1'h1;
    @(negedge clk_sys);
    check("gain red", 16'(gain_red), 16'h0080);
    rdchk("reset value", 4'h1, 8'hd0);
    rdchk("reset value", 4'hd, {4'h0, REV, 1'h0});
    test_done();
  end
endmodule : video_digitizer_control_regs_test

`default_nettype wire
